// ===== logic/mdp_defines.vh
// Constants for the MAC DMA master data port
`ifndef MDP_DEFINES_VH
`define MDP_DEFINES_VH
`define MDP_DIR_READ      1'b1
`define MDP_DIR_WRITE     1'b0
`define MDP_ST_IDLE       2'h0
`define MDP_ST_BUSY       2'h1
`define MDP_ST_DONE       2'h2
`define MDP_WIDTH_32      32
`define MDP_WIDTH_16      16
`define MDP_WIDTH_8       8
`define MDP_ALIGN_BITS_32 2
`define MDP_ALIGN_BITS_16 1
`define MDP_ALIGN_BITS_8  0
`define MDP_LEN_W         8
`define MDP_ADDR_W        32
`endif

// ===== logic/mdp_data_port.v
// DMA master data port: burst transfers to and from shared memory
`timescale 1ns/1ps
`include "mdp_defines.vh"

// Notes on behaviour
// - Request is high while a transfer is wanted
// - Direction stays constant while request is high
// - Direction high means read, low write
// - One word per edge with request and acknowledge
// - Acknowledge may drop anytime; advance only when acknowledged
// - End-of-burst flag marks the final burst beat
// - Write data is presented at bus width
// - 32-bit width: longword aligned addresses
// - 16-bit width: halfword aligned addresses
// - 8-bit width: byte aligned addresses
module mdp_data_port #(
  parameter BUS_WIDTH_PARAM     = `MDP_WIDTH_32,
  parameter ADDRESS_WIDTH_PARAM = `MDP_ADDR_W,
  parameter LEN_W               = `MDP_LEN_W
) (
  input  wire                           sys_clk_i,
  input  wire                           reset_i,
  // User side: burst command
  input  wire                           cmd_valid_i,
  output wire                           cmd_ready_o,
  input  wire                           cmd_read_i,
  input  wire [ADDRESS_WIDTH_PARAM-1:0] cmd_addr_i,
  input  wire [LEN_W-1:0]               cmd_len_i,
  // User side: write words
  input  wire [BUS_WIDTH_PARAM-1:0]     wr_word_i,
  output wire                           wr_take_o,
  // User side: read words
  output wire [BUS_WIDTH_PARAM-1:0]     rd_word_o,
  output wire                           rd_valid_o,
  output wire                           done_o,
  // Memory side
  output wire                           transfer_request_o,
  output wire                           direction_read_high_o,
  output wire [ADDRESS_WIDTH_PARAM-1:0] memory_address_out_o,
  output wire [BUS_WIDTH_PARAM-1:0]     write_word_out_o,
  output wire                           burst_end_flag_o,
  input  wire                           host_acknowledge_i,
  input  wire [BUS_WIDTH_PARAM-1:0]     read_word_in_i
);

  // State codes of the burst sequencer
  localparam [1:0] ST_IDLE = `MDP_ST_IDLE;
  localparam [1:0] ST_BUSY = `MDP_ST_BUSY;
  localparam [1:0] ST_DONE = `MDP_ST_DONE;

  // Address bits below ALIGN carry no meaning at this bus width
  localparam ALIGN = (BUS_WIDTH_PARAM == `MDP_WIDTH_32) ?
                     `MDP_ALIGN_BITS_32 :
                     (BUS_WIDTH_PARAM == `MDP_WIDTH_16) ?
                     `MDP_ALIGN_BITS_16 : `MDP_ALIGN_BITS_8;
  localparam [ADDRESS_WIDTH_PARAM-1:0] STEP =
    {{(ADDRESS_WIDTH_PARAM-1){1'b0}}, 1'b1} << ALIGN;
  localparam [LEN_W-1:0] LEN_ONE = {{(LEN_W-1){1'b0}}, 1'b1};

  // Clear the low bits that the bus width makes meaningless
  function [ADDRESS_WIDTH_PARAM-1:0] align_addr;
    input [ADDRESS_WIDTH_PARAM-1:0] a;
    begin
      align_addr = (a >> ALIGN) << ALIGN;
    end
  endfunction

  // A zero length counts as one beat, so a command never stalls
  function last_left;
    input [LEN_W-1:0] n;
    begin
      last_left = (n <= LEN_ONE);
    end
  endfunction

  reg  [1:0]                     state_r;
  reg  [1:0]                     state_nxt;
  reg  [LEN_W-1:0]               left_r;
  reg  [LEN_W-1:0]               left_nxt;
  reg                            dir_r;
  reg                            dir_nxt;
  reg  [ADDRESS_WIDTH_PARAM-1:0] addr_r;
  reg  [ADDRESS_WIDTH_PARAM-1:0] addr_nxt;
  reg  [BUS_WIDTH_PARAM-1:0]     wdata_r;
  reg  [BUS_WIDTH_PARAM-1:0]     wdata_nxt;
  reg  [BUS_WIDTH_PARAM-1:0]     rdata_r;
  reg  [BUS_WIDTH_PARAM-1:0]     rdata_nxt;
  reg                            rvalid_r;
  reg                            rvalid_nxt;
  reg                            done_r;
  reg                            done_nxt;
  wire                           busy;
  wire                           cmd_take;
  wire                           beat;
  wire                           last;

  assign busy     = (state_r == ST_BUSY);
  assign cmd_take = (state_r == ST_IDLE) & cmd_valid_i;
  assign beat     = busy & host_acknowledge_i;
  assign last     = busy & last_left(left_r);

  assign cmd_ready_o           = (state_r == ST_IDLE);
  assign transfer_request_o    = busy;
  assign burst_end_flag_o      = last;
  assign direction_read_high_o = dir_r;
  assign memory_address_out_o  = addr_r;
  assign write_word_out_o      = wdata_r;
  assign rd_word_o             = rdata_r;
  assign rd_valid_o            = rvalid_r;
  assign done_o                = done_r;

  // A take loads the shown word; the user then shows the next one
  assign wr_take_o = (cmd_take & (cmd_read_i == `MDP_DIR_WRITE)) |
                     (beat & ~last & (dir_r == `MDP_DIR_WRITE));

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // Wait cycles leave the sequencer where it is
        if (beat && last) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Next values on the memory side
  always @* begin
    dir_nxt   = dir_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    left_nxt  = left_r;
    if (cmd_take) begin
      // Direction only changes while request is low
      dir_nxt  = cmd_read_i ? `MDP_DIR_READ : `MDP_DIR_WRITE;
      addr_nxt = align_addr(cmd_addr_i);
      left_nxt = cmd_len_i;
      if (cmd_read_i == `MDP_DIR_WRITE) begin
        wdata_nxt = wr_word_i;
      end
    end else if (beat) begin
      // Nothing moves without acknowledge; wait cycles hold all
      addr_nxt = addr_r + STEP;
      left_nxt = left_r - LEN_ONE;
      if (dir_r == `MDP_DIR_WRITE && !last) begin
        wdata_nxt = wr_word_i;
      end
    end
  end

  // Next values on the user side
  always @* begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    done_nxt   = (state_r == ST_DONE);
    if (beat && dir_r == `MDP_DIR_READ) begin
      rdata_nxt  = read_word_in_i;
      rvalid_nxt = 1'b1;
    end
  end

  // Sequencer state; a wait cycle keeps it in place
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Beats left in the burst
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      left_r <= {LEN_W{1'b0}};
    end else begin
      left_r <= left_nxt;
    end
  end

  // Direction, address and write-word outputs come straight from these flip-flops
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      dir_r   <= `MDP_DIR_WRITE;
      addr_r  <= {ADDRESS_WIDTH_PARAM{1'b0}};
      wdata_r <= {BUS_WIDTH_PARAM{1'b0}};
    end else begin
      dir_r   <= dir_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // User-side read word and pulses
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_r  <= {BUS_WIDTH_PARAM{1'b0}};
      rvalid_r <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      done_r   <= done_nxt;
    end
  end

endmodule

// ===== dv/mdp_data_port_props.sv
// Checker for the DMA master data port
`timescale 1ns/1ps
module mdp_data_port_props #(
  parameter BUS_WIDTH_PARAM     = 32,
  parameter ADDRESS_WIDTH_PARAM = 32
) (
  input wire                           sys_clk_i,
  input wire                           reset_i,
  input wire                           cmd_valid_i,
  input wire                           cmd_ready_o,
  input wire                           cmd_read_i,
  input wire                           transfer_request_o,
  input wire                           direction_read_high_o,
  input wire                           done_o,
  input wire                           burst_end_flag_o,
  input wire                           host_acknowledge_i,
  input wire                           rd_valid_o,
  input wire [ADDRESS_WIDTH_PARAM-1:0] memory_address_out_o,
  input wire [BUS_WIDTH_PARAM-1:0]     write_word_out_o,
  input wire [BUS_WIDTH_PARAM-1:0]     read_word_in_i,
  input wire [BUS_WIDTH_PARAM-1:0]     rd_word_o
);
  wire req = transfer_request_o;
  wire beat = req && host_acknowledge_i;
  wire dir = direction_read_high_o;
  wire [ADDRESS_WIDTH_PARAM-1:0] adr = memory_address_out_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence last_beat; beat && burst_end_flag_o; endsequence
  sequence cmd_take; cmd_valid_i && cmd_ready_o; endsequence
  chk_dir_hold: assert property (req && $past(req) |-> $stable(dir))
    else $error("dir moved");
  chk_wait_hold: assert property (req && !beat |=> req &&
    $stable(adr) && $stable(write_word_out_o) &&
    $stable(burst_end_flag_o)) else $error("wait moved");
  chk_addr_align: assert property (req |->
    adr % (BUS_WIDTH_PARAM / 8) == 0) else $error("unaligned");
  chk_req_start: assert property (cmd_take |=>
    req && dir == $past(cmd_read_i)) else $error("bad start");
  chk_addr_step: assert property (beat && !burst_end_flag_o |=>
    adr == $past(adr) + BUS_WIDTH_PARAM / 8) else $error("bad step");
  chk_burst_end: assert property (last_beat |=> !req ##1 done_o)
    else $error("bad end");
  chk_read_word: assert property (beat && dir |=> rd_valid_o &&
    rd_word_o == $past(read_word_in_i)) else $error("bad read");
  chk_read_cause: assert property (rd_valid_o |->
    $past(beat) && $past(dir)) else $error("stray read");
endmodule
bind mdp_data_port mdp_data_port_props #(.BUS_WIDTH_PARAM(BUS_WIDTH_PARAM),
  .ADDRESS_WIDTH_PARAM(ADDRESS_WIDTH_PARAM)) i_mdp_data_port_props (.*);

// ===== dv/mdp_host_model.sv
// Host memory model answering with optional wait cycles
`timescale 1ns/1ps
module mdp_host_model (
  input  wire        sys_clk_i,
  input  wire        slow_i,
  input  wire        req_i,
  input  wire [31:0] addr_i,
  output wire        ack_o,
  output wire [31:0] data_o
);
  reg [1:0] tick_r = 2'h0;
  always @(posedge sys_clk_i) tick_r <= tick_r + 2'h1;
  // Slow mode stalls three cycles of four, also mid-burst
  assign ack_o = req_i && (!slow_i || tick_r == 2'h0);
  // Released data toggles so a stale word never matches
  assign data_o = ack_o ? ~addr_i : {16{tick_r}};
endmodule

// ===== dv/mdp_data_port_test.sv
// Self-checking bench for the DMA master data port
`timescale 1ns/1ps
module mdp_data_port_test;
  reg sys_clk_i = 0, reset_i = 1, cmd_valid_i = 0, cmd_read_i = 0, slow = 0;
  reg [31:0] cmd_addr_i = 0, ba = 0, wk = 0;
  reg [7:0] cmd_len_i = 0;
  integer nb = 0, nr = 0, bn = 1, num_errors = 0, checks_done = 0;
  reg brd = 0;
  wire cmd_ready_o, wr_take_o, rd_valid_o, done_o, transfer_request_o;
  wire direction_read_high_o, burst_end_flag_o, host_acknowledge_i;
  wire [31:0] memory_address_out_o, write_word_out_o, read_word_in_i;
  wire [31:0] rd_word_o, wr_word_i = 32'ha0 + wk;
  mdp_data_port i_mdp_data_port (.*);
  mdp_host_model i_mdp_host_model (.sys_clk_i(sys_clk_i), .slow_i(slow),
    .req_i(transfer_request_o), .addr_i(memory_address_out_o),
    .ack_o(host_acknowledge_i), .data_o(read_word_in_i));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task check(input [31:0] seen, input [31:0] want); begin
    checks_done = checks_done + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  end endtask
  task tally_and_finish; begin
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  always @(posedge sys_clk_i) if (wr_take_o) wk <= wk + 32'h1;
  always @(posedge sys_clk_i) begin
    if (transfer_request_o && host_acknowledge_i) begin
      check(memory_address_out_o, ba + nb * 4);
      check(direction_read_high_o, brd);
      check(burst_end_flag_o, nb + 1 >= bn);
      if (!direction_read_high_o)
        check(write_word_out_o, 32'ha0 + nb);
      nb <= nb + 1;
    end
    if (rd_valid_o) begin
      check(rd_word_o, ~(ba + nb * 4 - 32'h4));
      nr <= nr + 1;
    end
  end
  task burst(input rd, input s, input [31:0] a, input [7:0] n);
    integer i;
    begin
      @(negedge sys_clk_i);
      check(cmd_ready_o, 1'b1);
      {cmd_valid_i, cmd_read_i, slow} = {1'b1, rd, s};
      {cmd_addr_i, cmd_len_i} = {a, n};
      ba = a & 32'hfffffffc;
      brd = rd;
      bn = (n == 8'h0) ? 1 : n;
      nb = 0;
      nr = 0;
      wk = 32'h0;
      @(negedge sys_clk_i) cmd_valid_i = 0;
      check(transfer_request_o, 1'b1);
      for (i = 0; i < 80 && done_o !== 1'b1; i = i + 1) @(negedge sys_clk_i);
      if (i == 80) begin
        num_errors = num_errors + 1;
        tally_and_finish;
      end else begin
        check(nb, bn);
        check(nr, rd ? bn : 0);
        check(wk, rd ? 0 : bn);
      end
    end
  endtask
  initial begin
    repeat (6) @(negedge sys_clk_i);
    reset_i = 0;
    burst(1'b0, 1'b1, 32'h103, 8'h3);
    burst(1'b1, 1'b0, 32'h200, 8'h2);
    burst(1'b0, 1'b0, 32'hfc, 8'h0);
    burst(1'b1, 1'b1, 32'h40, 8'h4);
    tally_and_finish;
  end
endmodule
